//--- rtl/pmc_pkg.sv
// Shared constants and types for the power mode controller
`default_nettype none
package pmc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_MODE      = 8'h00;
    localparam logic [7:0] OFF_ACT_TMPL  = 8'h04;
    localparam logic [7:0] OFF_ALT_TMPL  = 8'h08;
    localparam logic [7:0] OFF_WAKE_EN   = 8'h0C;
    localparam logic [7:0] OFF_WAKE_STAT = 8'h10;
    localparam logic [7:0] OFF_TW_PERIOD = 8'h14;
    localparam logic [7:0] OFF_BOOST     = 8'h18;
    localparam logic [7:0] OFF_STATUS    = 8'h1C;

    // Widths
    localparam int NSUB  = 8;                  // Power-controllable subsystems
    localparam int NWAKE = 7;                  // Wakeup sources
    localparam int CPU_BIT = 0;                // Template bit of the processor

    // Wakeup source positions
    localparam int WK_PERIPH = 0;
    localparam int WK_SUPV   = 1;
    localparam int WK_TW     = 2;
    localparam int WK_PIN    = 3;
    localparam int WK_XRST   = 4;
    localparam int WK_WDOG   = 5;
    localparam int WK_PLVR   = 6;

    // Field positions in the boost register
    localparam int BOOST_VSEL_LSB = 0;
    localparam int BOOST_VSEL_W   = 6;
    localparam int BOOST_STBY_BIT = 8;
    localparam logic [5:0] VSEL_MAX = 6'h20;   // 1.8 V + 32 * 100 mV = 5.0 V

    // Reset values
    localparam logic [7:0]  ACT_TMPL_RST  = 8'hFF;
    localparam logic [7:0]  ALT_TMPL_RST  = 8'hFE;
    localparam logic [6:0]  WAKE_EN_RST   = 7'h7F;
    localparam logic [15:0] TW_PERIOD_RST = 16'h03E8;
    localparam logic [5:0]  VSEL_RST      = 6'h0F;

    // Mode request codes
    localparam logic [1:0] REQ_ACTIVE = 2'h0;
    localparam logic [1:0] REQ_ALT    = 2'h1;
    localparam logic [1:0] REQ_SLEEP  = 2'h2;
    localparam logic [1:0] REQ_HIB    = 2'h3;

    // Timing
    localparam int CLK_MHZ         = 200;
    localparam int SLEEP_RESUME_US = 15;
    localparam int SLEEP_RESUME_CYC = SLEEP_RESUME_US * CLK_MHZ;
    localparam int HIB_RESUME_US   = 100;
    localparam int HIB_RESUME_CYC  = HIB_RESUME_US * CLK_MHZ - 1;
    localparam int BOOST_KHZ       = 400;
    localparam int BOOST_DIV       = CLK_MHZ * 1000 / BOOST_KHZ;
    localparam int TW_US_DIV       = CLK_MHZ;  // One microsecond tick

    // Global power modes
    typedef enum logic [2:0] {
        M_ACTIVE,
        M_ALT,
        M_SLEEP,
        M_SLEEP_RESUME,
        M_HIB,
        M_HIB_RESUME
    } mode_t;
endpackage : pmc_pkg
`default_nettype wire

//--- rtl/tw_if.sv
// Link between the controller and its periodic timewheel
`default_nettype none
interface tw_if;
    logic        run;      // Timewheel counting allowed
    logic [15:0] period;   // Period in microseconds
    logic        tick;     // One-cycle periodic event
    modport ctrl (output run, output period, input tick);
    modport wheel (input run, input period, output tick);
endinterface : tw_if
`default_nettype wire

//--- rtl/timewheel.sv
// Periodic timewheel that raises a wakeup tick
`default_nettype none
module timewheel (
    input  wire logic pclk,     // System clock
    input  wire logic presetn,  // Async reset, active low
    tw_if.wheel       tw        // Controller link
);
    logic [7:0]  us_q;          // Microsecond prescaler
    logic [15:0] cnt_q;         // Microseconds elapsed
    logic        tick_q;        // Registered tick
    logic        us_tick;       // One-microsecond enable

    assign us_tick = (us_q == 8'(pmc_pkg::TW_US_DIV - 1));
    assign tw.tick = tick_q;

    // Prescaler to a one-microsecond enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            us_q <= 8'h00;
        else if (!tw.run || us_tick)
            us_q <= 8'h00;
        else
            us_q <= us_q + 8'h01;
    end

    // Period counter, ticks once per period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q  <= 16'h0000;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= 1'b0;
            if (!tw.run || tw.period == 16'h0000)
                cnt_q <= 16'h0000;
            else if (us_tick)
            begin
                if (cnt_q >= tw.period - 16'h0001)
                begin
                    cnt_q  <= 16'h0000;
                    tick_q <= 1'b1;         // Periodic wake event
                end
                else
                    cnt_q <= cnt_q + 16'h0001;
            end
        end
    end
endmodule : timewheel
`default_nettype wire

//--- rtl/power_mode_controller.sv
// Global power mode controller with APB registers and boost coordination
`default_nettype none
// How it works
// - Active mode applies active template bits
// - Disabled resources lose clock and bias
// - Processor may disable itself; wake re-enables
// - Wake forces active mode and processor on
// - Reset starts in active mode
// - Alternate active uses its own template
// - Sleep exit waits 15 us resume
// - Hibernate holds state, outputs, pin settings
// - Hibernate exits on pin interrupt, under 100 us
// - Enabled interrupts and resets act as wakeups
// - Central timewheel gives periodic wake interrupts
// - Boost voltage 1.8 to 5.0 V, 100 mV steps
// - Boost oscillator 400 kHz; active or standby
// - Boost active in active and alternate active
// - Sleep with boost standby wakes periodically
// - Boost kept active during hibernate
// - Sleep disables resources regardless of templates
// - Separate template register per templated mode
module power_mode_controller #(
    parameter int HIB_RESUME_CYCLES = pmc_pkg::HIB_RESUME_CYC  // Hibernate resume length
) (
    input  wire logic        pclk,          // System clock, 200 MHz
    input  wire logic        presetn,       // Async reset, active low
    input  wire logic        psel,          // APB select
    input  wire logic        penable,       // APB enable
    input  wire logic        pwrite,        // APB direction
    input  wire logic [7:0]  paddr,         // APB byte address
    input  wire logic [31:0] pwdata,        // APB write data
    output logic      [31:0] prdata,        // APB read data
    output logic             pready,        // APB ready
    output logic             pslverr,       // APB error
    input  wire logic        periph_irq,    // Peripheral interrupt, async
    input  wire logic        supervisor_irq, // Power supervisor interrupt, async
    input  wire logic        pin_interrupt_unit, // Pin interrupt, async
    input  wire logic        external_reset_pin, // External reset event, async
    input  wire logic        watchdog_reset_source, // Watchdog reset event, async
    input  wire logic        precise_low_voltage_reset, // Precise LV reset event, async
    output logic      [7:0]  clk_en,        // Per-subsystem clock enable
    output logic      [7:0]  bias_en,       // Per-subsystem analog bias enable
    output logic             cpu_en,        // Processor enable
    output logic             retain,        // Hold config, memory and pin state
    output logic             boost_active,  // Boost mode: 1 active, 0 standby
    output logic      [5:0]  boost_vsel,    // Boost voltage code
    output logic             boost_osc_tick // 400 kHz switching enable
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    pmc_pkg::mode_t  mode_q;                 // Global power mode
    logic [7:0]  act_tmpl_q;                 // Active template
    logic [7:0]  alt_tmpl_q;                 // Alternate active template
    logic [6:0]  wake_en_q;                  // Wakeup enables
    logic [6:0]  wake_stat_q;                // Sticky wakeup status
    logic [15:0] tw_period_q;                // Timewheel period
    logic [5:0]  vsel_q;                     // Boost voltage code
    logic        stby_q;                     // Boost standby in sleep allowed
    logic [14:0] resume_q;                   // Resume countdown
    logic [8:0]  bdiv_q;                     // Boost oscillator divider
    logic [31:0] prdata_q;                   // Registered read data
    logic [7:0]  en_q;                       // Registered subsystem enable
    logic [5:0]  src_raw;                    // Raw async sources
    logic [5:0]  s1_q;                       // Synchroniser first stage
    logic [5:0]  s2_q;                       // Synchroniser second stage
    logic [5:0]  s3_q;                       // Edge history
    logic [6:0]  src_evt;                    // Source events this cycle
    logic [6:0]  wake_hit;                   // Enabled events
    logic        wake;                       // Wakeup this cycle
    logic        setup;                      // APB setup phase
    logic        wr;                         // APB write access
    logic        mapped;                     // Address decodes
    logic        mode_wr;                    // Mode request write
    tw_if        tw ();                      // Timewheel link

    ////////////////////////////////////////////////////////////////////////
    // Timewheel
    timewheel u_tw (
        .pclk    (pclk),
        .presetn (presetn),
        .tw      (tw)
    );
    assign tw.run    = (mode_q != pmc_pkg::M_HIB);  // No clocks in hibernate
    assign tw.period = tw_period_q;

    ////////////////////////////////////////////////////////////////////////
    // Wakeup source synchronisers and edge detection
    assign src_raw = {precise_low_voltage_reset, watchdog_reset_source, external_reset_pin,
                      pin_interrupt_unit, supervisor_irq, periph_irq};

    // Two flops per async source, then an edge-history flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q <= 6'h00;
            s2_q <= 6'h00;
            s3_q <= 6'h00;
        end
        else
        begin
            s1_q <= src_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Rising edges and the timewheel tick mapped onto wakeup source positions
    assign src_evt[pmc_pkg::WK_PERIPH] = s2_q[0] & ~s3_q[0];
    assign src_evt[pmc_pkg::WK_SUPV]   = s2_q[1] & ~s3_q[1];
    assign src_evt[pmc_pkg::WK_TW]     = tw.tick;
    assign src_evt[pmc_pkg::WK_PIN]    = s2_q[2] & ~s3_q[2];
    assign src_evt[pmc_pkg::WK_XRST]   = s2_q[3] & ~s3_q[3];
    assign src_evt[pmc_pkg::WK_WDOG]   = s2_q[4] & ~s3_q[4];
    assign src_evt[pmc_pkg::WK_PLVR]   = s2_q[5] & ~s3_q[5];

    // Which events may wake, depending on mode
    always_comb
    begin
        wake_hit = src_evt & wake_en_q;
        if (mode_q == pmc_pkg::M_HIB)
            wake_hit = src_evt & 7'(1 << pmc_pkg::WK_PIN);         // Pin only
        else if (mode_q == pmc_pkg::M_SLEEP && stby_q)
            wake_hit[pmc_pkg::WK_TW] = src_evt[pmc_pkg::WK_TW];    // Boost refresh
    end
    assign wake = |wake_hit;

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    assign setup   = psel & ~penable;
    assign wr      = psel & penable & pwrite;
    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    always_comb
    begin
        mapped = 1'b1;
        if (paddr == pmc_pkg::OFF_MODE)           mapped = 1'b1;
        else if (paddr == pmc_pkg::OFF_ACT_TMPL)  mapped = 1'b1;
        else if (paddr == pmc_pkg::OFF_ALT_TMPL)  mapped = 1'b1;
        else if (paddr == pmc_pkg::OFF_WAKE_EN)   mapped = 1'b1;
        else if (paddr == pmc_pkg::OFF_WAKE_STAT) mapped = 1'b1;
        else if (paddr == pmc_pkg::OFF_TW_PERIOD) mapped = 1'b1;
        else if (paddr == pmc_pkg::OFF_BOOST)     mapped = 1'b1;
        else if (paddr == pmc_pkg::OFF_STATUS)    mapped = 1'b1;
        else                                      mapped = 1'b0;
    end
    assign pslverr = psel & penable & ~mapped;
    assign mode_wr = wr & (paddr == pmc_pkg::OFF_MODE);

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (setup && !pwrite)
        begin
            if (paddr == pmc_pkg::OFF_MODE)
                prdata_q <= {29'h0, mode_q};
            else if (paddr == pmc_pkg::OFF_ACT_TMPL)
                prdata_q <= {24'h0, act_tmpl_q};
            else if (paddr == pmc_pkg::OFF_ALT_TMPL)
                prdata_q <= {24'h0, alt_tmpl_q};
            else if (paddr == pmc_pkg::OFF_WAKE_EN)
                prdata_q <= {25'h0, wake_en_q};
            else if (paddr == pmc_pkg::OFF_WAKE_STAT)
                prdata_q <= {25'h0, wake_stat_q};
            else if (paddr == pmc_pkg::OFF_TW_PERIOD)
                prdata_q <= {16'h0, tw_period_q};
            else if (paddr == pmc_pkg::OFF_BOOST)
                prdata_q <= {23'h0, stby_q, 2'h0, vsel_q};
            else if (paddr == pmc_pkg::OFF_STATUS)
                prdata_q <= {22'h0, boost_active, en_q[pmc_pkg::CPU_BIT], en_q};
            else
                prdata_q <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            act_tmpl_q  <= pmc_pkg::ACT_TMPL_RST;
            alt_tmpl_q  <= pmc_pkg::ALT_TMPL_RST;
            wake_en_q   <= pmc_pkg::WAKE_EN_RST;
            tw_period_q <= pmc_pkg::TW_PERIOD_RST;
            vsel_q      <= pmc_pkg::VSEL_RST;
            stby_q      <= 1'b0;
        end
        else
        begin
            if (wr && paddr == pmc_pkg::OFF_ACT_TMPL)
                act_tmpl_q <= pwdata[7:0];                       // Any time
            if (wr && paddr == pmc_pkg::OFF_ALT_TMPL)
                alt_tmpl_q <= pwdata[7:0];
            if (wr && paddr == pmc_pkg::OFF_WAKE_EN)
                wake_en_q <= pwdata[6:0];
            if (wr && paddr == pmc_pkg::OFF_TW_PERIOD)
                tw_period_q <= pwdata[15:0];
            if (wr && paddr == pmc_pkg::OFF_BOOST)
            begin
                // Codes above 5.0 V are clamped
                if (pwdata[5:0] > pmc_pkg::VSEL_MAX)
                    vsel_q <= pmc_pkg::VSEL_MAX;
                else
                    vsel_q <= pwdata[5:0];
                stby_q <= pwdata[pmc_pkg::BOOST_STBY_BIT];
            end
            if (wake)
                act_tmpl_q[pmc_pkg::CPU_BIT] <= 1'b1;            // Processor back on
        end
    end

    // Sticky wakeup status, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wake_stat_q <= 7'h00;
        else if (wr && paddr == pmc_pkg::OFF_WAKE_STAT)
            wake_stat_q <= (wake_stat_q & ~pwdata[6:0]) | src_evt;
        else
            wake_stat_q <= wake_stat_q | src_evt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Power mode sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q   <= pmc_pkg::M_ACTIVE;                        // Boot mode
            resume_q <= 15'h0000;
        end
        else
        begin
            case (mode_q)
                pmc_pkg::M_ACTIVE, pmc_pkg::M_ALT:
                begin
                    if (wake)
                        mode_q <= pmc_pkg::M_ACTIVE;
                    else if (mode_wr)
                    begin
                        case (pwdata[1:0])
                            pmc_pkg::REQ_ALT:   mode_q <= pmc_pkg::M_ALT;
                            pmc_pkg::REQ_SLEEP: mode_q <= pmc_pkg::M_SLEEP;
                            pmc_pkg::REQ_HIB:   mode_q <= pmc_pkg::M_HIB;
                            default:            mode_q <= pmc_pkg::M_ACTIVE;
                        endcase
                    end
                end
                pmc_pkg::M_SLEEP:
                begin
                    if (wake)
                    begin
                        mode_q   <= pmc_pkg::M_SLEEP_RESUME;
                        resume_q <= 15'(pmc_pkg::SLEEP_RESUME_CYC - 1);
                    end
                end
                pmc_pkg::M_HIB:
                begin
                    if (wake)
                    begin
                        mode_q   <= pmc_pkg::M_HIB_RESUME;
                        resume_q <= 15'(HIB_RESUME_CYCLES - 1);
                    end
                end
                pmc_pkg::M_SLEEP_RESUME, pmc_pkg::M_HIB_RESUME:
                begin
                    // Regulators settle, then straight to active
                    if (resume_q == 15'h0000)
                        mode_q <= pmc_pkg::M_ACTIVE;
                    else
                        resume_q <= resume_q - 15'h0001;
                end
                default:
                    mode_q <= pmc_pkg::M_ACTIVE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Subsystem enables from the mode's template
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            en_q <= pmc_pkg::ACT_TMPL_RST;
        else if (mode_q == pmc_pkg::M_ACTIVE)
            en_q <= act_tmpl_q;
        else if (mode_q == pmc_pkg::M_ALT)
            en_q <= alt_tmpl_q;
        else
            en_q <= 8'h00;                                       // Templates ignored
    end
    assign clk_en  = en_q;                                       // Gated clocks
    assign bias_en = en_q;                                       // Bias off
    assign cpu_en  = en_q[pmc_pkg::CPU_BIT];

    // Retention: registers are never reset by mode, only outputs are held
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            retain <= 1'b0;
        else
            retain <= (mode_q == pmc_pkg::M_HIB);
    end

    ////////////////////////////////////////////////////////////////////////
    // Boost coordination
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            boost_active <= 1'b1;
        else if (mode_q == pmc_pkg::M_SLEEP)
            boost_active <= ~stby_q;                             // Standby allowed
        else if (mode_q == pmc_pkg::M_HIB)
            boost_active <= 1'b1;
        else
            boost_active <= 1'b1;
    end
    assign boost_vsel = vsel_q;

    // Fixed 400 kHz switching enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bdiv_q <= 9'h000;
        else if (bdiv_q == 9'(pmc_pkg::BOOST_DIV - 1))
            bdiv_q <= 9'h000;
        else
            bdiv_q <= bdiv_q + 9'h001;
    end
    assign boost_osc_tick = boost_active && (bdiv_q == 9'h000);
endmodule : power_mode_controller
`default_nettype wire

//--- tb/power_mode_controller_properties.sv
// Port-level checker for the power mode controller
`default_nettype none
module power_mode_controller_properties (
    input wire logic       pclk,               // Clock
    input wire logic       presetn,            // Reset, active low
    input wire logic       psel,               // APB select
    input wire logic       penable,            // APB enable
    input wire logic [7:0] paddr,              // APB address
    input wire logic       pready,             // APB ready
    input wire logic       pslverr,            // APB error
    input wire logic       pin_interrupt_unit, // Pin event
    input wire logic [7:0] clk_en,             // Clock enables
    input wire logic [7:0] bias_en,            // Bias enables
    input wire logic       cpu_en,             // Processor enable
    input wire logic       retain,             // Hibernate hold
    input wire logic       boost_active,       // Boost mode
    input wire logic [5:0] boost_vsel,         // Boost voltage code
    input wire logic       boost_osc_tick      // Boost switching tick
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    // Enables, wake, hibernate, boost and APB behaviour
    a_bias_clk_pair: assert property (bias_en == clk_en)
        else $error("bias enables differ from clock enables");
    a_cpu_bit_zero: assert property (cpu_en == clk_en[0])
        else $error("processor enable differs from its template bit");
    a_wake_cpu_on: assert property ($rose(pin_interrupt_unit) && clk_en != 8'h00 |-> ##[1:8] cpu_en)
        else $error("processor not enabled after a wake");
    a_hib_dark: assert property (retain |-> clk_en == 8'h00 && boost_active)
        else $error("clocks running or boost standby in hibernate");
    // The 60 cycle bound holds for any resume length, as retain drops when the resume starts
    a_hib_exit_time: assert property ($rose(pin_interrupt_unit) && retain |-> ##[1:60] !retain)
        else $error("hibernate not left after a pin event");
    a_boost_in_run: assert property (clk_en != 8'h00 |-> boost_active)
        else $error("boost in standby while subsystems run");
    a_tick_spacing: assert property (boost_osc_tick |=> !boost_osc_tick [*8])
        else $error("boost ticks too close together");
    a_tick_standby: assert property (!boost_active |-> !boost_osc_tick)
        else $error("boost tick while in standby");
    a_vsel_range: assert property (boost_vsel <= 6'h20)
        else $error("boost voltage code above 5.0 V");
    a_unmapped_err: assert property (psel && penable && paddr > 8'h1C |-> pslverr && pready)
        else $error("unmapped access not refused");
    ////////////////////////////////////////////////////////////////////////
    // Main scenarios reached
    c_hib_entry: cover property ($rose(retain));
    c_cpu_off: cover property ($fell(cpu_en));
    c_refused: cover property (pslverr);
endmodule : power_mode_controller_properties
bind power_mode_controller power_mode_controller_properties u_props (
    .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .pin_interrupt_unit,
    .clk_en, .bias_en, .cpu_en, .retain, .boost_active, .boost_vsel, .boost_osc_tick);
`default_nettype wire

//--- tb/power_mode_controller_tb_top.sv
// Self-checking bench for the power mode controller
`default_nettype none
module power_mode_controller_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HIB = 20;                  // Short hibernate resume
    logic        pclk, presetn;               // Clock and reset
    logic        psel, penable, pwrite;       // APB controls
    logic [7:0]  paddr;                       // APB address
    logic [31:0] pwdata, prdata;              // APB data
    logic        pready, pslverr;             // APB answer
    logic [5:0]  ev;                          // Wake event inputs
    logic [7:0]  clk_en, bias_en;             // Subsystem enables
    logic        cpu_en, retain, boost_active, boost_osc_tick; // Status outputs
    logic [5:0]  boost_vsel;                  // Boost voltage code
    logic [31:0] mdl [8];                     // Register model
    logic [31:0] rd;                          // Last read data
    logic        er;                          // Last error flag
    int          n_errors, n_compared, cnt;   // Counters
    power_mode_controller #(.HIB_RESUME_CYCLES(HIB)) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .periph_irq(ev[0]), .supervisor_irq(ev[1]), .pin_interrupt_unit(ev[2]),
        .external_reset_pin(ev[3]), .watchdog_reset_source(ev[4]), .precise_low_voltage_reset(ev[5]),
        .clk_en, .bias_en, .cpu_en, .retain, .boost_active, .boost_vsel, .boost_osc_tick);
    ////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////////////
    // Compare, bus and wait tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        if (a == 8'h18)
            mdl[6] = (d & 32'h100) | ((d[5:0] > 6'h20) ? 32'h20 : {26'h0, d[5:0]});
        else if (a != 8'h00 && a != 8'h10)
            mdl[a[4:2]] = d & ((a == 8'h14) ? 32'hFFFF : 32'hFF);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc
    task automatic settle();
        repeat (8) @(posedge pclk);
    endtask : settle
    task automatic wait_cpu(input int bound);
        cnt = 0;
        while (cpu_en !== 1'b1 && cnt < bound)
        begin
            @(posedge pclk);
            cnt++;
        end
        chk({31'h0, cpu_en}, 32'h1);
    endtask : wait_cpu
    task automatic finish_test();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ev} = '0;
        void'($urandom(32'hAC14));
        mdl = '{32'h0, 32'hFF, 32'hFE, 32'h7F, 32'h0, 32'd1000, 32'h0F, 32'h3FF};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) rdc(8'(i * 4), mdl[i]);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h04, $urandom & 32'hFF);
            settle();
            chk({24'h0, clk_en}, mdl[1]);
            chk({24'h0, bias_en}, mdl[1]);
        end
        wr(8'h04, 32'hFE);
        settle();
        chk({31'h0, cpu_en}, 32'h0);
        ev[2] <= 1'b1;
        wait_cpu(20);
        ev[2] <= 1'b0;
        mdl[1] = mdl[1] | 32'h1;
        rdc(8'h04, mdl[1]);
        rdc(8'h10, 32'h8);
        wr(8'h10, 32'h8);
        rdc(8'h10, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            wr(8'h08, $urandom & 32'hFE);
            wr(8'h00, 32'h1);
            settle();
            chk({24'h0, clk_en}, mdl[2]);
            chk({31'h0, boost_active}, 32'h1);
            rdc(8'h00, 32'h1);
            ev[i] <= 1'b1;
            settle();
            ev[i] <= 1'b0;
            rdc(8'h00, 32'h0);
            chk({24'h0, clk_en}, mdl[1]);
        end
        wr(8'h18, 32'h13F);
        settle();
        chk({26'h0, boost_vsel}, 32'h20);
        rdc(8'h18, mdl[6]);
        cnt = 0;
        repeat (1000) @(posedge pclk) cnt += boost_osc_tick;
        chk(cnt, 32'h2);
        wr(8'h00, 32'h2);
        settle();
        chk({clk_en, 7'h0, boost_active}, 32'h0);
        ev[0] <= 1'b1;
        wait_cpu(4000);
        ev[0] <= 1'b0;
        chk(32'(cnt >= 3000 && cnt <= 3012), 32'h1);
        wr(8'h18, 32'h0F);
        wr(8'h00, 32'h3);
        settle();
        chk({clk_en, 6'h0, retain, boost_active}, 32'h3);
        ev[0] <= 1'b1; // Peripheral event, not a wakeup in hibernate
        repeat (40) @(posedge pclk);
        ev[0] <= 1'b0;
        settle();
        chk({31'h0, retain}, 32'h1);
        ev[2] <= 1'b1;
        wait_cpu(200);
        ev[2] <= 1'b0;
        chk(32'(cnt <= HIB + 12), 32'h1);
        wr(8'h14, 32'h1);
        wr(8'h00, 32'h2);
        settle();
        wait_cpu(4000);
        chk(32'(cnt > 0 && cnt < 4000), 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd & 32'h4, 32'h4);
        finish_test();
    end
endmodule : power_mode_controller_tb_top
`default_nettype wire
